/* rtl/xad_core.v */
`timescale 1ns/1ps
`include "xad_consts.vh"

module xad_core (
    input  wire        core_clk,  // Core clock, 125 MHz
    input  wire        rst_n,     // Async reset, active low
    input  wire [7:0]  progData,  // Program byte at progAddr, same cycle
    input  wire [7:0]  portPin,   // Port pin levels
    output wire [15:0] progAddr,  // Program counter
    output wire [7:0]  accOut,    // Accumulator
    output wire [7:0]  pswOut,    // Status word, parity in bit 0
    output wire [15:0] ptrOut,    // Sixteen-bit pointer
    output wire [7:0]  portOut,   // Port output latch
    output wire        instrDone  // Pulse: previous instruction retired
);

    // ------------------------------------------------------------------
    // States and cycle limits
    // ------------------------------------------------------------------
    localparam [6:0] S_FETCH = 7'b0000001;
    localparam [6:0] S_BYTE2 = 7'b0000010;
    localparam [6:0] S_BYTE3 = 7'b0000100;
    localparam [6:0] S_PTR   = 7'b0001000;
    localparam [6:0] S_READ  = 7'b0010000;
    localparam [6:0] S_EXEC  = 7'b0100000;
    localparam [6:0] S_WAIT  = 7'b1000000;
    localparam [3:0] LAST1   = `XAD_LAST1_CLK;
    localparam [3:0] LAST2   = `XAD_LAST2_CLK;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function [3:0] fnOp;
        input [7:0] op;
        begin
            if (op == `XAD_OPC_INC_PTR)
                fnOp = `XAD_OP_INCPTR;
            else if (op == `XAD_OPC_BCD_ADJ)
                fnOp = `XAD_OP_BCDADJ;
            else if (op[3:0] < 4'h4 && op != `XAD_OPC_XOR_DIR_A && op != `XAD_OPC_XOR_DIR_IM)
                fnOp = `XAD_OP_NOP;
            else if (op[7:4] == `XAD_GRP_INC)
                fnOp = `XAD_OP_INC;
            else if (op[7:4] == `XAD_GRP_DEC)
                fnOp = `XAD_OP_DEC;
            else if (op[7:4] == `XAD_GRP_ADD)
                fnOp = `XAD_OP_ADD;
            else if (op[7:4] == `XAD_GRP_SUM_WITH_CARRY_OP)
                fnOp = `XAD_OP_SUM_WITH_CARRY_OP;
            else if (op[7:4] == `XAD_GRP_DIFFERENCE_WITH_BORROW_OP)
                fnOp = `XAD_OP_DIFFERENCE_WITH_BORROW_OP;
            else if (op[7:4] == `XAD_GRP_XOR)
                fnOp = `XAD_OP_XOR;
            else
                fnOp = `XAD_OP_NOP;
        end
    endfunction

    function [2:0] fnSrc;
        input [7:0] op;
        begin
            if (fnOp(op) == `XAD_OP_NOP || op == `XAD_OPC_INC_PTR)
                fnSrc = `XAD_SRC_NONE;
            else if (op == `XAD_OPC_BCD_ADJ)
                fnSrc = `XAD_SRC_ACC;
            else if (op[3])
                fnSrc = `XAD_SRC_REG;
            else if (op[2:1] == 2'b11)
                fnSrc = `XAD_SRC_IND;
            else if (op[2:0] == 3'b100)
                fnSrc = (op[7:5] == 3'b000) ? `XAD_SRC_ACC : `XAD_SRC_IMM;
            else
                fnSrc = `XAD_SRC_DIR;  // x5, 62, 63
        end
    endfunction

    // Length in bytes
    function [1:0] fnLen;
        input [7:0] op;
        begin
            if (op == `XAD_OPC_XOR_DIR_IM)
                fnLen = 2'd3;
            else if (fnSrc(op) == `XAD_SRC_DIR || fnSrc(op) == `XAD_SRC_IMM)
                fnLen = 2'd2;
            else
                fnLen = 2'd1;
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers and internal nets
    // ------------------------------------------------------------------
    reg  [6:0]  state_q, state_d;
    reg  [15:0] pc_q, pc_d;
    reg  [7:0]  opcode_q, byte2_q, byte3_q, opAddr_q;
    reg  [7:0]  acc_q, acc_d;
    reg  [7:1]  flags_q, flags_d;
    reg  [15:0] ptr_q, ptr_d;
    reg  [7:0]  latch_q, latch_d;
    reg  [3:0]  clkCnt_q;
    reg         done_q;
    reg  [7:0]  ramAddr;
    reg  [7:0]  sfrVal;
    reg  [7:0]  res;
    reg         locWr;
    wire [7:0]  ramRd;
    wire [3:0]  opK      = fnOp(opcode_q);
    wire [2:0]  srcK     = fnSrc(opcode_q);
    wire        destDir  = (opcode_q == `XAD_OPC_XOR_DIR_A) || (opcode_q == `XAD_OPC_XOR_DIR_IM);
    wire        twoCyc   = (opcode_q == `XAD_OPC_XOR_DIR_IM) || (opcode_q == `XAD_OPC_INC_PTR);
    wire        lastClk  = (clkCnt_q == (twoCyc ? LAST2 : LAST1));
    wire        locIsSfr = (srcK == `XAD_SRC_DIR) && byte2_q[7];
    wire        rmw      = destDir || opK == `XAD_OP_INC || opK == `XAD_OP_DEC;
    wire [1:0]  bank     = flags_q[`XAD_PSW_BANK_HI:`XAD_PSW_BANK_LO];
    wire        cy       = flags_q[`XAD_PSW_CY];
    wire        ac       = flags_q[`XAD_PSW_AC];
    wire [7:0]  locVal   = locIsSfr ? sfrVal : ramRd;
    wire [7:0]  bVal     = (srcK == `XAD_SRC_IMM) ? byte2_q : locVal;
    wire        cin      = (opK == `XAD_OP_SUM_WITH_CARRY_OP) ? cy : 1'b0;

    // Arithmetic datapath; 9-bit sums keep the carry and borrow
    wire [8:0] addSum  = {1'b0, acc_q} + {1'b0, bVal} + {8'h00, cin};
    wire [4:0] addLow  = {1'b0, acc_q[3:0]} + {1'b0, bVal[3:0]} + {4'h0, cin};
    wire       addOv   = (acc_q[7] == bVal[7]) && (addSum[7] != acc_q[7]);
    wire [8:0] subDiff = {1'b0, acc_q} - {1'b0, bVal} - {8'h00, cy};
    wire [4:0] subLow  = {1'b0, acc_q[3:0]} - {1'b0, bVal[3:0]} - {4'h0, cy};
    wire       subOv   = (acc_q[7] != bVal[7]) && (subDiff[7] != acc_q[7]);
    wire       lowFix  = (acc_q[3:0] > 4'h9) || ac;
    wire [8:0] daT1    = {1'b0, acc_q} + (lowFix ? 9'h006 : 9'h000);
    wire       hiFix   = daT1[8] || cy || (daT1[7:4] > 4'h9);
    wire [8:0] daT2    = daT1 + (hiFix ? 9'h060 : 9'h000);

    // ------------------------------------------------------------------
    // Special function register read
    // ------------------------------------------------------------------
    // Read-modify-write takes the port latch so pin loading cannot
    // corrupt bits that software never meant to touch
    always @*
    begin
        if (byte2_q == `XAD_SFR_ACC)
            sfrVal = acc_q;
        else if (byte2_q == `XAD_SFR_PSW)
            sfrVal = {flags_q, ^acc_q};
        else if (byte2_q == `XAD_SFR_PTRLO)
            sfrVal = ptr_q[7:0];
        else if (byte2_q == `XAD_SFR_PTRHI)
            sfrVal = ptr_q[15:8];
        else if (byte2_q == `XAD_SFR_PORT)
            sfrVal = rmw ? latch_q : portPin;
        else
            sfrVal = 8'h00;
    end

    // ------------------------------------------------------------------
    // RAM address: pointer register, then operand, then write-back
    // ------------------------------------------------------------------
    always @*
    begin
        if (state_q == S_PTR)
            ramAddr = {3'b000, bank, 2'b00, opcode_q[0]};
        else if (state_q == S_READ && srcK == `XAD_SRC_REG)
            ramAddr = {3'b000, bank, opcode_q[2:0]};
        else if (state_q == S_READ && srcK == `XAD_SRC_IND)
            ramAddr = ramRd;
        else if (state_q == S_READ)
            ramAddr = byte2_q;
        else
            ramAddr = opAddr_q;
    end

    // ------------------------------------------------------------------
    // Execute: result, flags and write-back
    // ------------------------------------------------------------------
    always @*
    begin
        acc_d   = acc_q;
        flags_d = flags_q;
        ptr_d   = ptr_q;
        latch_d = latch_q;
        locWr   = 1'b0;
        res     = 8'h00;
        if (state_q == S_EXEC)
        begin
            case (opK)
                `XAD_OP_ADD, `XAD_OP_SUM_WITH_CARRY_OP:
                begin
                    acc_d                 = addSum[7:0];
                    flags_d[`XAD_PSW_CY]  = addSum[8];
                    flags_d[`XAD_PSW_AC]  = addLow[4];
                    flags_d[`XAD_PSW_OV]  = addOv;
                end
                `XAD_OP_DIFFERENCE_WITH_BORROW_OP:
                begin
                    acc_d                 = subDiff[7:0];
                    flags_d[`XAD_PSW_CY]  = subDiff[8];
                    flags_d[`XAD_PSW_AC]  = subLow[4];
                    flags_d[`XAD_PSW_OV]  = subOv;
                end
                `XAD_OP_INC, `XAD_OP_DEC:
                begin
                    if (srcK == `XAD_SRC_ACC)
                        res = (opK == `XAD_OP_INC) ? acc_q + 8'h01 : acc_q - 8'h01;
                    else
                        res = (opK == `XAD_OP_INC) ? locVal + 8'h01 : locVal - 8'h01;
                    if (srcK == `XAD_SRC_ACC)
                        acc_d = res;
                    else
                        locWr = 1'b1;
                end
                `XAD_OP_XOR:
                begin
                    // Flags untouched; parity tracks the accumulator
                    if (opcode_q == `XAD_OPC_XOR_DIR_IM)
                        res = locVal ^ byte3_q;
                    else
                        res = locVal ^ acc_q;
                    if (destDir)
                        locWr = 1'b1;
                    else
                        acc_d = acc_q ^ bVal;
                end
                `XAD_OP_INCPTR:
                begin
                    ptr_d = ptr_q + 16'h0001;
                end
                `XAD_OP_BCDADJ:
                begin
                    acc_d                = daT2[7:0];
                    flags_d[`XAD_PSW_CY] = cy | daT1[8] | daT2[8];
                end
                default:
                begin
                    res = 8'h00;
                end
            endcase
            // Direct writes above 7fh land in the registers themselves
            if (locWr && locIsSfr)
            begin
                if (byte2_q == `XAD_SFR_ACC)
                    acc_d = res;
                else if (byte2_q == `XAD_SFR_PSW)
                    flags_d = res[7:1];
                else if (byte2_q == `XAD_SFR_PTRLO)
                    ptr_d = {ptr_q[15:8], res};
                else if (byte2_q == `XAD_SFR_PTRHI)
                    ptr_d = {res, ptr_q[7:0]};
                else if (byte2_q == `XAD_SFR_PORT)
                    latch_d = res;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Every instruction fills its machine cycles exactly, so timing
    // does not depend on how many internal steps it needed
    always @*
    begin
        state_d = state_q;
        pc_d    = pc_q;
        case (state_q)
            S_FETCH:
            begin
                pc_d = pc_q + 16'h0001;
                if (fnLen(progData) != 2'd1)
                    state_d = S_BYTE2;
                else if (fnSrc(progData) == `XAD_SRC_IND)
                    state_d = S_PTR;
                else
                    state_d = S_READ;
            end
            S_BYTE2:
            begin
                pc_d    = pc_q + 16'h0001;
                state_d = (fnLen(opcode_q) == 2'd3) ? S_BYTE3 : S_READ;
            end
            S_BYTE3:
            begin
                pc_d    = pc_q + 16'h0001;
                state_d = S_READ;
            end
            S_PTR:
                state_d = S_READ;
            S_READ:
                state_d = S_EXEC;
            S_EXEC, S_WAIT:
                state_d = lastClk ? S_FETCH : S_WAIT;
            default:
                state_d = S_FETCH;
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= S_FETCH;
            pc_q     <= `XAD_RST_PC;
            opcode_q <= 8'h00;
            byte2_q  <= 8'h00;
            byte3_q  <= 8'h00;
            opAddr_q <= 8'h00;
            acc_q    <= `XAD_RST_ACC;
            flags_q  <= `XAD_RST_FLAGS;
            ptr_q    <= `XAD_RST_PTR;
            latch_q  <= `XAD_RST_PORT;
            clkCnt_q <= 4'h0;
            done_q   <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            pc_q     <= pc_d;
            acc_q    <= acc_d;
            flags_q  <= flags_d;
            ptr_q    <= ptr_d;
            latch_q  <= latch_d;
            clkCnt_q <= (state_d == S_FETCH) ? 4'h0 : clkCnt_q + 4'h1;
            done_q   <= (state_d == S_FETCH) && (state_q != S_FETCH);
            if (state_q == S_FETCH)
                opcode_q <= progData;
            if (state_q == S_BYTE2)
                byte2_q <= progData;
            if (state_q == S_BYTE3)
                byte3_q <= progData;
            if (state_q == S_READ)
                opAddr_q <= ramAddr;
        end
    end

    // ------------------------------------------------------------------
    // Internal RAM
    // ------------------------------------------------------------------
    xad_ram u_ram (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ramAddr  (ramAddr),
        .ramWe    (locWr && !locIsSfr),
        .ramWdata (res),
        .ramRdata (ramRd)
    );

    // Parity is live from the accumulator
    assign progAddr  = pc_q;
    assign accOut    = acc_q;
    assign pswOut    = {flags_q, ^acc_q};
    assign ptrOut    = ptr_q;
    assign portOut   = latch_q;
    assign instrDone = done_q;

endmodule

/* rtl/xad_consts.vh */
`ifndef XAD_CONSTS_VH
`define XAD_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Clocks of core_clk that make one machine cycle
`define XAD_CLKS_PER_CYC   4
// Last clock count of a one- and a two-cycle instruction; keep in step
`define XAD_LAST1_CLK      4'h3
`define XAD_LAST2_CLK      4'h7

// ----------------------------------------------------------------------
// Opcode groups (upper nibble) and single opcodes
// ----------------------------------------------------------------------
`define XAD_GRP_INC        4'h0
`define XAD_GRP_DEC        4'h1
`define XAD_GRP_ADD        4'h2
`define XAD_GRP_SUM_WITH_CARRY_OP       4'h3
`define XAD_GRP_XOR        4'h6
`define XAD_GRP_DIFFERENCE_WITH_BORROW_OP       4'h9
`define XAD_OPC_XOR_DIR_A  8'h62
`define XAD_OPC_XOR_DIR_IM 8'h63
`define XAD_OPC_INC_PTR    8'ha3
`define XAD_OPC_BCD_ADJ    8'hd4

// ----------------------------------------------------------------------
// Operation classes
// ----------------------------------------------------------------------
`define XAD_OP_NOP         4'h0
`define XAD_OP_ADD         4'h1
`define XAD_OP_SUM_WITH_CARRY_OP        4'h2
`define XAD_OP_DIFFERENCE_WITH_BORROW_OP        4'h3
`define XAD_OP_INC         4'h4
`define XAD_OP_DEC         4'h5
`define XAD_OP_XOR         4'h6
`define XAD_OP_INCPTR      4'h7
`define XAD_OP_BCDADJ      4'h8

// ----------------------------------------------------------------------
// Operand source kinds
// ----------------------------------------------------------------------
`define XAD_SRC_ACC        3'h0
`define XAD_SRC_IMM        3'h1
`define XAD_SRC_DIR        3'h2
`define XAD_SRC_IND        3'h3
`define XAD_SRC_REG        3'h4
`define XAD_SRC_NONE       3'h5

// ----------------------------------------------------------------------
// Special function register addresses (direct space 80h..ffh)
// ----------------------------------------------------------------------
`define XAD_SFR_ACC        8'he0
`define XAD_SFR_PSW        8'hd0
`define XAD_SFR_PTRLO      8'h82
`define XAD_SFR_PTRHI      8'h83
`define XAD_SFR_PORT       8'h90

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define XAD_PSW_CY         7
`define XAD_PSW_AC         6
`define XAD_PSW_BANK_HI    4
`define XAD_PSW_BANK_LO    3
`define XAD_PSW_OV         2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define XAD_RST_PC         16'h0000
`define XAD_RST_ACC        8'h00
`define XAD_RST_FLAGS      7'h00
`define XAD_RST_PTR        16'h0000
`define XAD_RST_PORT       8'hff

// ----------------------------------------------------------------------
// Internal RAM geometry
// ----------------------------------------------------------------------
`define XAD_RAM_AW         8
`define XAD_RAM_DEPTH      256

`endif

/* rtl/xad_ram.v */
`timescale 1ns/1ps
`include "xad_consts.vh"

// ----------------------------------------------------------------------
// Internal data RAM, single port, registered read
// ----------------------------------------------------------------------
module xad_ram (
    input  wire                   core_clk, // Core clock
    input  wire                   rst_n,    // Async reset, clears read register only
    input  wire [`XAD_RAM_AW-1:0] ramAddr,  // Read or write address
    input  wire                   ramWe,    // Write strobe
    input  wire [7:0]             ramWdata, // Write data
    output wire [7:0]             ramRdata  // Read data, one clock after address
);

    reg [7:0] mem [0:`XAD_RAM_DEPTH-1];
    reg [7:0] rdata_q;

    // Array has no reset; software must initialise it
    always @(posedge core_clk)
    begin
        if (ramWe)
        begin
            mem[ramAddr] <= ramWdata;
        end
    end

    // Read register; a write cycle reads back the old value
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= mem[ramAddr];
        end
    end

    assign ramRdata = rdata_q;

endmodule

/* bench/xad_rom.sv */
`timescale 1ns/1ps
// ------------------------------
// Program memory, asynchronous read
// ------------------------------
module xad_rom (
    input  logic [15:0] progAddr, // Fetch address
    output logic [7:0]  progData  // Byte, same cycle
);
    logic [7:0] mem [0:255];
    // Past the image a one-byte no-op keeps the core in step
    assign progData = (progAddr[15:8] == 8'h00) ? mem[progAddr[7:0]] : 8'ha5;
endmodule

/* bench/xad_chk.sv */
`timescale 1ns/1ps
// ------------------------------
// Decode core port checker
// ------------------------------
module xad_chk (
    input logic        core_clk,  // Clock
    input logic        rst_n,     // Reset
    input logic [7:0]  progData,  // Fetch byte
    input logic [7:0]  portPin,   // Pins
    input logic [15:0] progAddr,  // Counter
    input logic [7:0]  accOut,    // Accumulator
    input logic [7:0]  pswOut,    // Status
    input logic [15:0] ptrOut,    // Pointer
    input logic [7:0]  portOut,   // Latch
    input logic        instrDone  // Retire
);
    // All checks sleep through reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Opcode seen in the first clock after a retire
    sequence s_fetch(logic [7:0] op);
        instrDone && progData == op;
    endsequence
    // Next retire exactly one machine cycle on
    sequence s_next4;
        !instrDone [*3] ##1 instrDone;
    endsequence
    property p_len4(logic [7:0] op, int n);
        s_fetch(op) |=> s_next4 ##0 progAddr == $past(progAddr, 4) + n;
    endproperty
    a_retire_gap: assert property (instrDone |=> !instrDone [*3])
        else $error("retire pulses too close");
    a_pc_step: assert property ($changed(progAddr) |-> progAddr == $past(progAddr) + 1)
        else $error("counter jumped");
    a_xor_imm_val: assert property (s_fetch(8'h64) |=> s_next4 ##0
        accOut == ($past(accOut, 4) ^ $past(progData, 3)) && pswOut[0] == ^accOut
        && pswOut[7:1] == $past(pswOut[7:1], 4))
        else $error("immediate xor wrong");
    a_xor_dir_len: assert property (p_len4(8'h65, 2))
        else $error("xor direct length wrong");
    a_xor_to_dir: assert property (s_fetch(8'h62) |=> s_next4 ##0
        accOut == $past(accOut, 4) && progAddr == $past(progAddr, 4) + 2)
        else $error("xor into direct wrong");
    a_port_latch: assert property (s_fetch(8'h63) ##1 progData == 8'h90 |=>
        !instrDone [*6] ##1 instrDone && portOut == ($past(portOut, 8) ^ $past(progData, 6)))
        else $error("port xor immediate wrong");
    a_ptr_inc: assert property (s_fetch(8'ha3) |=> !instrDone [*7] ##1
        instrDone && ptrOut == $past(ptrOut, 8) + 1)
        else $error("pointer increment wrong");
    a_bcd_len: assert property (p_len4(8'hd4, 1))
        else $error("decimal adjust length wrong");
    a_add_len: assert property (p_len4(8'h24, 2))
        else $error("add immediate length wrong");
endmodule
bind xad_core xad_chk i_xad_chk (.core_clk(core_clk), .rst_n(rst_n), .progData(progData),
    .portPin(portPin), .progAddr(progAddr), .accOut(accOut), .pswOut(pswOut),
    .ptrOut(ptrOut), .portOut(portOut), .instrDone(instrDone));

/* bench/xad_core_bench.sv */
`timescale 1ns/1ps
module xad_core_bench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  portPin = 8'h00;
    logic [7:0]  progData, accOut, pswOut, portOut;
    logic [15:0] progAddr, ptrOut, startAddr;
    logic        instrDone;
    logic [7:0]  prog [$];
    int          errorCnt = 0;
    int          comparisons = 0;
    // ------------------------------
    // Clock, memory and core
    // ------------------------------
    always #4 core_clk = ~core_clk;
    xad_rom i_xad_rom (.progAddr(progAddr), .progData(progData));
    xad_core i_xad_core (.core_clk(core_clk), .rst_n(rst_n), .progData(progData),
        .portPin(portPin), .progAddr(progAddr), .accOut(accOut), .pswOut(pswOut),
        .ptrOut(ptrOut), .portOut(portOut), .instrDone(instrDone));
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic closeOut;
        $display("comparisons=%0d mismatches=%0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait for the retire pulse, counting clocks
    task automatic waitDone(output int clks);
        for (clks = 1; clks <= 40; clks++)
        begin
            @(posedge core_clk);
            #1;
            if (instrDone === 1'b1)
                return;
        end
        check(16'h0000, 16'h0001);
        closeOut();
    endtask
    // Load image, reset 16 clocks, retire the leading filler byte
    task automatic startProg(input logic [7:0] pins);
        int c;
        @(posedge core_clk);
        rst_n <= 1'b0;
        portPin <= pins;
        for (int i = 0; i < 256; i++)
            i_xad_rom.mem[i] = (i < prog.size()) ? prog[i] : 8'ha5;
        // Known RAM image: each byte holds its address xor 5a
        for (int i = 0; i < 256; i++)
            i_xad_core.u_ram.mem[i] = 8'(i) ^ 8'h5a;
        repeat (16) @(posedge core_clk);
        #1;
        check({accOut, portOut}, 16'h00ff);
        check(progAddr, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        waitDone(c);
        check(progAddr, 16'h0001);
        startAddr = progAddr;
    endtask
    // Four clocks per cycle; counter moves by the byte length
    task automatic step(input int nb, input int cyc);
        int c;
        waitDone(c);
        check(16'(c), 16'(cyc * 4));
        check(progAddr, startAddr + 16'(nb));
        startAddr = progAddr;
    endtask
    task automatic arith(input int nb, input logic [7:0] acc, input logic [1:0] cp);
        step(nb, 1);
        check(accOut, acc);
        check({pswOut[7], pswOut[0]}, cp);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    // Pins differ from the latch, so a wrong read source shows
    task automatic testXorForms;
        prog = '{8'ha5, 8'h64, 8'hc7, 8'h65, 8'h90, 8'h62, 8'h90, 8'h63, 8'h90, 8'h31,
            8'h65, 8'he0};
        startProg(8'haa);
        step(2, 1);
        check({accOut, pswOut}, 16'hc701);
        step(2, 1);
        check({accOut, pswOut}, 16'h6d01);
        step(2, 1);
        check({accOut, portOut}, 16'h6d92);
        step(3, 2);
        check(portOut, 8'ha3);
        step(2, 1);
        check({accOut, pswOut}, 16'h0000);
        $display("xor forms finished");
    endtask
    task automatic testArith;
        prog = '{8'ha5, 8'h24, 8'h15, 8'h25, 8'h90, 8'h34, 8'h41, 8'h94, 8'h0f, 8'h04,
            8'h05, 8'h82, 8'h14, 8'h15, 8'h83, 8'ha3, 8'hd4};
        startProg(8'haa);
        arith(2, 8'h15, 2'b01);
        arith(2, 8'hbf, 2'b01);
        arith(2, 8'h00, 2'b10);
        arith(2, 8'hf0, 2'b10);
        arith(1, 8'hf1, 2'b11);
        step(2, 1);
        check(ptrOut, 16'h0001);
        arith(1, 8'hf0, 2'b10);
        step(2, 1);
        check(ptrOut, 16'hff01);
        step(1, 2);
        check(ptrOut, 16'hff02);
        step(1, 1);
        check(accOut, 8'h56);
        $display("arith forms finished");
    endtask
    // RAM preloaded with address xor 5a, so bank and indirect sources show in A
    task automatic testRamForms;
        logic [7:0] ops [16] = '{8'h08, 8'h06, 8'h18, 8'h17, 8'h05, 8'h15, 8'h68, 8'h6f,
            8'h66, 8'h67, 8'h28, 8'h36, 8'h98, 8'h65, 8'h37, 8'h95};
        logic [7:0] accExp [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h5d,
            8'h00, 8'h01, 8'h5a, 8'h00, 8'ha6, 8'h6a, 8'h01, 8'h96};
        for (int k = 0; k < 16; k++)
        begin
            prog = '{8'ha5, ops[k], 8'h30};
            startProg(8'h00);
            step((ops[k][3:0] == 4'h5) ? 2 : 1, 1);
            check(accOut, accExp[k]);
        end
        $display("ram forms finished");
    endtask
    initial
    begin
        testXorForms();
        testArith();
        testRamForms();
        closeOut();
    end
endmodule
